// >>> sapp_pkg.sv
// Summary of operation
// - Offset write word: low 12 bits signed offset, upper 3 bits zero.
// - Host keeps offset between -1310 and +1310.
// - New offset may be written any time between conversions.
// - Mode straps must be 0,1 or 1,0; equal values forbidden.
// - Host never reads during a conversion.
// - Host may hold chip select low and use only read strobe.
// - Host leaves a quiet gap after bus activity before next sample start.
package sapp_pkg;
   // register byte offsets of the controller's own APB map
   localparam logic [7:0] CTRL_ADDR   = 8'h00;
   localparam logic [7:0] OFFSET_ADDR = 8'h04;
   localparam logic [7:0] STATUS_ADDR = 8'h08;
   localparam logic [7:0] RESULT_ADDR = 8'h0c;
   // control fields
   localparam int CTRL_START  = 0;
   localparam int CTRL_WRITE  = 1;
   localparam int CTRL_MODE   = 2;
   localparam int CTRL_CLAMP  = 3;
   // result word fields
   localparam int RES_W       = 15;
   localparam int FLAG_BIT    = 14;
   localparam int SIGN_BIT    = 13;
   localparam int OFS_W       = 12;
   localparam logic signed [11:0] OFS_MIN = -12'sd1310;
   localparam logic signed [11:0] OFS_MAX = 12'sd1310;
   // timing in ns and derived cycles at 200 MHz
   localparam int CLK_NS      = 5;
   localparam int STROBE_NS   = 20;
   localparam int QUIET_NS    = 30;
   localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int QUIET_CYC   = (QUIET_NS + CLK_NS - 1) / CLK_NS;
   // status bits
   localparam int ST_BUSY     = 0;
   localparam int ST_DONE     = 1;
   localparam int ST_OFSERR   = 2;
   typedef enum logic [2:0] {
      SAPP_IDLE  = 3'b000,
      SAPP_CONV  = 3'b001,
      SAPP_READ  = 3'b011,
      SAPP_QUIET = 3'b010,
      SAPP_WRITE = 3'b110
   } sapp_state_e;
endpackage

// >>> sapp_decode.sv
`timescale 1ns/1ps
`default_nettype none
// classifies a raw result word read from the converter
module sapp_decode (
   input  wire logic [14:0] word,
   input  wire logic        clampOn,
   output logic             belowRange,
   output logic             aboveRange,
   output logic [31:0]      value
);
   // clamped words keep the flag as a plain marker; unclamped ones carry sign
   always_comb begin
      belowRange = 1'b0;
      aboveRange = 1'b0;
      value      = {17'h00000, word};
      if (word[sapp_pkg::FLAG_BIT]) begin
         if (!clampOn && word[sapp_pkg::SIGN_BIT]) begin
            belowRange = 1'b1;
            value      = {{17{1'b1}}, word};
         end else if (!clampOn) begin
            aboveRange = 1'b1;
         end else begin
            aboveRange = 1'b1;
            value      = {18'h00000, word[13:0]};
         end
      end // flag clear: in range
   end
endmodule
`default_nettype wire

// >>> sapp_host.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
module sapp_host (
   input  wire logic        clk,
   input  wire logic        sys_rst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             sample_start_n,
   output logic             chipSelect_n,
   output logic             readStrobe_n,
   output logic             writeStrobe_n,
   output logic             modeSel1,
   output logic             modeSel2,
   output logic             clamp_select,
   input  wire logic        convBusy_n,
   input  wire logic [14:0] resultLinesIn,
   output logic [14:0]      resultLinesOut,
   output logic [14:0]      resultLinesOe_n
);
   sapp_pkg::sapp_state_e state, next_state;
   logic [31:0] ctrl, next_ctrl;
   logic [11:0] offset, next_offset;
   logic [2:0]  status, next_status;
   logic [31:0] result, next_result;
   logic [7:0]  cnt, next_cnt;
   logic        pending, next_pending;
   logic        ofsPending, next_ofsPending;
   logic [14:0] word, next_word;
   logic        convN, next_convN, csN, next_csN, rdN, next_rdN, wrN, next_wrN;
   logic        oeN, next_oeN;
   logic [31:0] rdata, next_rdata;
   logic        busyS1, busyS2, busyS3;
   logic [14:0] dataS1, dataS2;
   logic        below, above;
   logic [31:0] decoded;
   logic        apbWr;
   logic        justRead, next_justRead;
   logic        modeOne, next_modeOne;

   // two-flop synchronisers for converter pins
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busyS1 <= 1'b1;
         busyS2 <= 1'b1;
         busyS3 <= 1'b1;
         dataS1 <= 15'h0000;
         dataS2 <= 15'h0000;
      end else begin
         busyS1 <= convBusy_n;
         busyS2 <= busyS1;
         busyS3 <= busyS2;
         dataS1 <= resultLinesIn;
         dataS2 <= dataS1;
      end
   end

   sapp_decode sapp_decode_i (
      .word       (word),
      .clampOn    (ctrl[sapp_pkg::CTRL_CLAMP]),
      .belowRange (below),
      .aboveRange (above),
      .value      (decoded)
   );

   assign apbWr = psel && penable && pwrite;

   // register file, sequencer and pin drive
   always_comb begin
      next_state      = state;
      next_ctrl       = ctrl;
      next_offset     = offset;
      next_status     = status;
      next_result     = result;
      next_cnt        = cnt;
      next_pending    = pending;
      next_ofsPending = ofsPending;
      next_word       = word;
      next_convN      = convN;
      next_csN        = csN;
      next_rdN        = rdN;
      next_wrN        = wrN;
      next_oeN        = oeN;
      next_rdata      = 32'h00000000;
      next_justRead   = 1'b0;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            sapp_pkg::CTRL_ADDR:   next_rdata = ctrl;
            sapp_pkg::OFFSET_ADDR: next_rdata = {20'h00000, offset};
            sapp_pkg::STATUS_ADDR: next_rdata = {29'h00000000, status};
            sapp_pkg::RESULT_ADDR: next_rdata = result;
            default:               next_rdata = 32'h00000000;
         endcase
      end
      if (apbWr) begin
         case (paddr)
            sapp_pkg::CTRL_ADDR: begin
               next_ctrl = {28'h0000000, pwdata[3:2], 2'b00};
               if (pwdata[sapp_pkg::CTRL_START]) next_pending = 1'b1;
               if (pwdata[sapp_pkg::CTRL_WRITE]) next_ofsPending = 1'b1;
            end
            sapp_pkg::OFFSET_ADDR: begin
               // out-of-span offsets refused and flagged
               if ($signed(pwdata[11:0]) < sapp_pkg::OFS_MIN ||
                   $signed(pwdata[11:0]) > sapp_pkg::OFS_MAX) begin
                  next_status[sapp_pkg::ST_OFSERR] = 1'b1;
               end else begin
                  next_offset = pwdata[11:0];
               end
            end
            sapp_pkg::STATUS_ADDR: begin
               // write one to clear; hardware set below wins
               next_status = status & ~pwdata[2:0];
            end
            default: ;
         endcase
      end
      // registered copy so the strap pin needs no inverter
      next_modeOne = !next_ctrl[sapp_pkg::CTRL_MODE];
      case (state)
         sapp_pkg::SAPP_IDLE: begin
            if (ofsPending) begin
               next_ofsPending = 1'b0;
               next_state      = sapp_pkg::SAPP_WRITE;
               next_csN        = 1'b0;
               next_wrN        = 1'b0;
               next_oeN        = 1'b0;
               next_cnt        = 8'(sapp_pkg::STROBE_CYC);
            end else if (pending) begin
               next_pending = 1'b0;
               next_state   = sapp_pkg::SAPP_CONV;
               next_convN   = 1'b0;
               next_cnt     = 8'(sapp_pkg::STROBE_CYC);
            end
         end
         sapp_pkg::SAPP_CONV: begin
            if (cnt != 8'h00) next_cnt = cnt - 8'h01;
            else next_convN = 1'b1;
            // no strobe until conversion flag rises
            if (busyS2 && !busyS3) begin
               next_state = sapp_pkg::SAPP_READ;
               next_csN   = 1'b0; // holding it low for good is also legal
               next_rdN   = 1'b0;
               next_convN = 1'b1;
               next_cnt   = 8'(sapp_pkg::STROBE_CYC + 2);
            end
         end
         sapp_pkg::SAPP_READ: begin
            if (cnt != 8'h00) begin
               next_cnt = cnt - 8'h01;
            end else begin
               next_word  = dataS2;
               next_justRead = 1'b1;
               next_csN   = 1'b1;
               next_rdN   = 1'b1;
               next_state = sapp_pkg::SAPP_QUIET;
               next_cnt   = 8'(sapp_pkg::QUIET_CYC);
            end
         end
         sapp_pkg::SAPP_WRITE: begin
            if (cnt != 8'h00) begin
               next_cnt = cnt - 8'h01;
            end else begin
               // chip select stays low one more cycle: the word is taken on the rising strobe
               next_wrN   = 1'b1;
               next_state = sapp_pkg::SAPP_QUIET;
               next_cnt   = 8'(sapp_pkg::QUIET_CYC);
            end
         end
         sapp_pkg::SAPP_QUIET: begin
            next_csN = 1'b1;
            next_rdN = 1'b1;
            next_oeN = 1'b1;
            // quiet gap before any next sample start
            if (cnt != 8'h00) next_cnt = cnt - 8'h01;
            else next_state = sapp_pkg::SAPP_IDLE;
            // decoded word settles one cycle after the read; set wins over a clear
            if (justRead) begin
               next_result = {below, above, decoded[29:0]};
               next_status[sapp_pkg::ST_DONE] = 1'b1;
            end
         end
         default: next_state = sapp_pkg::SAPP_IDLE;
      endcase
      // busy covers queued requests too, so software never sees a false idle
      next_status[sapp_pkg::ST_BUSY] = (next_state != sapp_pkg::SAPP_IDLE) ||
                                       next_pending || next_ofsPending;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state      <= sapp_pkg::SAPP_IDLE;
         ctrl       <= 32'h00000000;
         offset     <= 12'h000;
         status     <= 3'h0;
         result     <= 32'h00000000;
         cnt        <= 8'h00;
         pending    <= 1'b0;
         ofsPending <= 1'b0;
         word       <= 15'h0000;
         convN      <= 1'b1;
         csN        <= 1'b1;
         rdN        <= 1'b1;
         wrN        <= 1'b1;
         oeN        <= 1'b1;
         rdata      <= 32'h00000000;
         justRead   <= 1'b0;
         modeOne    <= 1'b1;
      end else begin
         state      <= next_state;
         ctrl       <= next_ctrl;
         offset     <= next_offset;
         status     <= next_status;
         result     <= next_result;
         justRead   <= next_justRead;
         modeOne    <= next_modeOne;
         cnt        <= next_cnt;
         pending    <= next_pending;
         ofsPending <= next_ofsPending;
         word       <= next_word;
         convN      <= next_convN;
         csN        <= next_csN;
         rdN        <= next_rdN;
         wrN        <= next_wrN;
         oeN        <= next_oeN;
         rdata      <= next_rdata;
      end
   end

   // pin outputs straight from flops; upper three offset bits forced zero
   always_comb begin
      prdata          = rdata;
      pready          = 1'b1;
      pslverr         = 1'b0;
      sample_start_n  = convN;
      chipSelect_n    = csN;
      readStrobe_n    = rdN;
      writeStrobe_n   = wrN;
      modeSel1        = modeOne;
      modeSel2        = ctrl[sapp_pkg::CTRL_MODE];
      clamp_select    = ctrl[sapp_pkg::CTRL_CLAMP];
      resultLinesOut  = {3'b000, offset};
      resultLinesOe_n = {15{oeN}};
   end

   strobe_excl_a: assert property (@(posedge clk) disable iff (sys_rst)
      !(readStrobe_n == 1'b0 && writeStrobe_n == 1'b0))
      else $error("read and write strobes low together");
   no_read_conv_a: assert property (@(posedge clk) disable iff (sys_rst)
      (state == sapp_pkg::SAPP_CONV) |-> readStrobe_n)
      else $error("read strobe during conversion");
   write_drive_a: assert property (@(posedge clk) disable iff (sys_rst)
      !writeStrobe_n |-> !chipSelect_n && resultLinesOe_n == 15'h0000)
      else $error("write strobe without driven bus");
   write_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(writeStrobe_n) |-> !chipSelect_n && resultLinesOe_n == 15'h0000)
      else $error("chip select or bus released with the write strobe");
   upper_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
      resultLinesOut[14:12] == 3'b000)
      else $error("offset upper bits not zero");
   mode_legal_a: assert property (@(posedge clk) disable iff (sys_rst)
      modeSel1 != modeSel2)
      else $error("forbidden mode strap");
   quiet_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(writeStrobe_n) |-> sample_start_n [*4])
      else $error("sample start inside quiet gap");
   read_gap_a: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(readStrobe_n) |-> sample_start_n [*4])
      else $error("sample start inside quiet gap after read");
   offset_span_a: assert property (@(posedge clk) disable iff (sys_rst)
      $signed(offset) >= sapp_pkg::OFS_MIN && $signed(offset) <= sapp_pkg::OFS_MAX)
      else $error("offset outside span");
   rd_cs_a: assert property (@(posedge clk) disable iff (sys_rst)
      !readStrobe_n |-> !chipSelect_n && resultLinesOe_n[0])
      else $error("read without chip select or bus not released");
endmodule
`default_nettype wire

// >>> sapp_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural converter on the far side of the parallel port
module sapp_dev_model #(
   parameter int CONV_NS = 200
) (
   input  wire logic        sys_rst,
   input  wire logic        sample_start_n,
   input  wire logic        chipSelect_n,
   input  wire logic        readStrobe_n,
   input  wire logic        writeStrobe_n,
   input  wire logic        modeSel1,
   input  wire logic        modeSel2,
   input  wire logic        clamp_select,
   input  wire logic [13:0] rawIn,
   input  wire logic [14:0] busIn,
   output logic             convBusy_n,
   output logic [14:0]      devData,
   output logic             devOe,
   output int               ruleErr
);
   logic signed [11:0] offset;
   logic [14:0]        outReg;
   logic [14:0]        pending;
   logic signed [15:0] sum;
   realtime            lastBus;
   initial begin
      convBusy_n = 1'b1;
      ruleErr = 0;
      lastBus = 0;
      offset = '0;
      outReg = '0;
      pending = '0;
   end
   // host reset doubles as converter reset here
   always @(posedge sys_rst) offset = '0;
   // offset capture; a new write simply replaces the old value
   always @(posedge writeStrobe_n) begin
      if (!chipSelect_n && convBusy_n) begin
         if (busIn[14:12] !== 3'b000) ruleErr++;
         offset = busIn[11:0];
         lastBus = $realtime;
      end
   end
   // any bus release restarts the quiet interval
   always @(posedge readStrobe_n or posedge chipSelect_n) lastBus = $realtime;
   // reads during a conversion are a host fault
   always @(negedge chipSelect_n or negedge readStrobe_n) begin
      if (!chipSelect_n && !readStrobe_n && !convBusy_n) ruleErr++;
   end
   // conversion with offset add and range coding
   always @(negedge sample_start_n) begin
      if ($realtime - lastBus < sapp_pkg::QUIET_NS) ruleErr++;
      if (modeSel1 == modeSel2) ruleErr++;
      if (modeSel2) outReg = pending;
      convBusy_n = 1'b0;
      #(CONV_NS);
      sum = $signed({2'b00, rawIn}) + offset;
      if (clamp_select) begin
         pending = {sum < 0 || sum > 16383,
                    sum < 0 ? 14'h0000 : (sum > 16383 ? 14'h3fff : sum[13:0])};
      end else begin
         pending = sum[14:0];
      end
      if (modeSel1) outReg = pending;
      convBusy_n = 1'b1;
   end
   // lines float unless both selects are low
   assign devOe   = !chipSelect_n && !readStrobe_n;
   assign devData = outReg;
endmodule
`default_nettype wire

// >>> sar_adc_parallel_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module sar_adc_parallel_port_tb_top;
   logic clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, sample_start_n, chipSelect_n, readStrobe_n, writeStrobe_n;
   logic modeSel1, modeSel2, clamp_select, convBusy_n, devOe;
   logic [14:0] resultLinesOut, resultLinesOe_n, devData, busLevel, busLast = '0;
   logic [13:0] rawIn = '0;
   int fail_count = 0, checks = 0, cyc = 0, ruleErr;
   // undriven lines show the inverse of their last level
   assign busLevel = (~resultLinesOe_n & resultLinesOut) |
                     (resultLinesOe_n & (devOe ? devData : ~busLast));
   always @(posedge clk) busLast <= busLevel;
   sapp_host sapp_host_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .sample_start_n(sample_start_n), .chipSelect_n(chipSelect_n),
      .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n), .modeSel1(modeSel1),
      .modeSel2(modeSel2), .clamp_select(clamp_select), .convBusy_n(convBusy_n),
      .resultLinesIn(busLevel), .resultLinesOut(resultLinesOut),
      .resultLinesOe_n(resultLinesOe_n));
   sapp_dev_model sapp_dev_model_i (.sys_rst(sys_rst), .sample_start_n(sample_start_n),
      .chipSelect_n(chipSelect_n), .readStrobe_n(readStrobe_n),
      .writeStrobe_n(writeStrobe_n), .modeSel1(modeSel1), .modeSel2(modeSel2),
      .clamp_select(clamp_select), .rawIn(rawIn), .busIn(busLevel),
      .convBusy_n(convBusy_n), .devData(devData), .devOe(devOe), .ruleErr(ruleErr));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // hang guard, generous against the expected few hundred cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         $display("Error at %0t: timeout", $time);
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // apb cycles: request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // polls until idle; only the cycle guard ends a hang
   task automatic waitIdle();
      repeat (3) @(posedge clk);
      do begin
         apb(1'b0, sapp_pkg::STATUS_ADDR, '0);
      end while (rd[sapp_pkg::ST_BUSY] !== 1'b0);
   endtask
   task automatic wrOfs(input int v);
      apb(1'b1, sapp_pkg::OFFSET_ADDR, {20'h00000, v[11:0]});
      apb(1'b1, sapp_pkg::CTRL_ADDR, 32'h00000002);
      waitIdle();
   endtask
   // one conversion, result word compared under a mask
   task automatic conv(input logic [13:0] raw, input logic [31:0] ctl, input int s,
                       input logic [31:0] mask);
      logic [31:0] exp;
      exp = {s < 0, s > 16383, s[29:0]};
      rawIn <= raw;
      apb(1'b1, sapp_pkg::CTRL_ADDR, ctl | 32'h00000001);
      waitIdle();
      check(rd[sapp_pkg::ST_DONE], 1'b1);
      apb(1'b0, sapp_pkg::RESULT_ADDR, '0);
      check(rd & mask, exp & mask);
      apb(1'b1, sapp_pkg::STATUS_ADDR, 32'h00000002);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      conv(14'd500, 0, 500, '1);
      $display("test reset offset done");
      wrOfs(-512);
      conv(14'd500, 0, -12, '1);
      conv(14'd300, 0, -212, '1);
      $display("test negative offset done");
      wrOfs(1024);
      conv(14'd16000, 0, 17024, '1);
      conv(14'd16000, 32'h8, 16383, 32'h3fff);
      $display("test positive offset done");
      wrOfs(2000);
      apb(1'b0, sapp_pkg::STATUS_ADDR, '0);
      check(rd[sapp_pkg::ST_OFSERR], 1'b1);
      conv(14'd100, 0, 1124, '1);
      wrOfs(1310);
      apb(1'b0, sapp_pkg::OFFSET_ADDR, '0);
      check(rd, 32'h0000051e);
      conv(14'd0, 0, 1310, '1);
      $display("test offset limits done");
      conv(14'd100, 32'h4, 1310, '1);
      conv(14'd200, 32'h4, 1410, '1);
      $display("test second mode done");
      check(ruleErr, 0);
      finish_test();
   end
endmodule
`default_nettype wire
